// ---- rtl/sisc_pkg.sv ----
// Constants, register map and types of the status indicator and service controller
package sisc_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned BLINK_SLOW_HZ = 1;
  localparam int unsigned BLINK_MID_HZ = 2;
  localparam int unsigned BLINK_FAST_HZ = 3;
  // Half period counts, toggling twice per blink period
  localparam int unsigned HALF_SLOW_CYC = CLK_HZ / (2 * BLINK_SLOW_HZ);
  localparam int unsigned HALF_MID_CYC = CLK_HZ / (2 * BLINK_MID_HZ);
  localparam int unsigned HALF_FAST_CYC = CLK_HZ / (2 * BLINK_FAST_HZ);
  localparam int unsigned INIT_MS = 500;
  localparam int unsigned INIT_CYC = (CLK_HZ / 1000) * INIT_MS;
  localparam int unsigned RESTART_US = 10;
  localparam int unsigned RESTART_CYC = (CLK_HZ / 1000000) * RESTART_US;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_PWCODE = 8'h0C;
  localparam logic [7:0] ADDR_LAMP = 8'h10;

  // Command register bits, write one to trigger
  localparam int CMD_RESTART = 0;
  localparam int CMD_FACTORY = 1;
  localparam int CMD_START = 2;
  localparam int CMD_STOP = 3;
  localparam int CMD_IDENT_ON = 4;
  localparam int CMD_IDENT_OFF = 5;

  // Status register bits
  localparam int ST_INIT = 0;
  localparam int ST_SAFETY_RUN = 1;
  localparam int ST_MAINT_EN = 2;
  localparam int ST_CLIENT_EN = 3;
  localparam int ST_PW_DEFAULT = 4;
  localparam int ST_CFG_DEFAULT = 5;
  localparam int ST_IDENT = 6;
  localparam int ST_PW_REJECT = 7;

  // Control register bits
  localparam int CT_MAINT_EN = 0;
  localparam int CT_CLIENT_EN = 1;
  localparam int CT_PW_CHANGED = 2;

  localparam logic [31:0] PW_KEY_DEFAULT = 32'h5A5A_0001; // Arbitrary activation code
  localparam logic [2:0] CTRL_RESET = 3'h0;

  typedef enum logic [1:0] {
    SISC_LAMP_OFF,
    SISC_LAMP_RED,
    SISC_LAMP_YELLOW,
    SISC_LAMP_GREEN
  } sisc_color_e;

  typedef enum logic [1:0] {
    SISC_PH_INIT,
    SISC_PH_RUN,
    SISC_PH_RESTART
  } sisc_phase_e;
endpackage : sisc_pkg

// ---- rtl/sisc_top.sv ----
// Status lamps and service command logic with an AHB-Lite register slave
//
// Notes on behaviour
// - Output lamp green while outputs ON.
// - Output lamp red while outputs OFF.
// - Steady green only in normal mode.
// - Steady yellow while warning field interrupted.
// - Dark in sleep or safety stopped.
// - Identify blinks red and green alternately.
// - Device error blinks red.
// - Recoverable error blinks yellow 3 Hz.
// - Missing or faulty configuration: red/yellow.
// - Unverified configuration alternates yellow and green.
// - Restart delay blinks green 3 Hz.
// - Contamination warning blinks yellow 1 Hz.
// - Test mode blinks green 1 Hz.
// - Both lamps lit during power-up initialization.
// - Restart command equals power cycle.
// - Restart clears serious fault if cause gone.
// - Restart drops all communication links.
// - Factory reset restores defaults, groups, password.
// - Valid activation code resets password, groups.
// - Tool commands manually stop or start safety.
// - Contamination error blinks yellow 3 Hz.
// - Recoverable error forces outputs OFF.
`timescale 1ns/100ps
module sisc_top #(
  parameter int unsigned INIT_CYCLES = sisc_pkg::INIT_CYC,
  parameter int unsigned HALF_SLOW = sisc_pkg::HALF_SLOW_CYC,
  parameter int unsigned HALF_MID = sisc_pkg::HALF_MID_CYC,
  parameter int unsigned HALF_FAST = sisc_pkg::HALF_FAST_CYC,
  parameter logic [31:0] PW_KEY = sisc_pkg::PW_KEY_DEFAULT
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic safety_request_i,
  input wire logic cfg_present_i,
  input wire logic cfg_faulty_i,
  input wire logic cfg_verified_i,
  input wire logic device_error_i,
  input wire logic recoverable_error_i,
  input wire logic contam_error_i,
  input wire logic contam_warning_i,
  input wire logic warn_field_i,
  input wire logic restart_delay_i,
  input wire logic test_mode_i,
  input wire logic sleep_i,
  input wire logic fault_cleared_i,
  output logic safety_switching_output_o,
  output sisc_pkg::sisc_color_e output_lamp_o,
  output sisc_pkg::sisc_color_e status_lamp_o,
  output logic comm_drop_o,
  output logic core_reinit_o,
  output logic cfg_restore_o
);
  import sisc_pkg::*;

  sisc_phase_e phase_r;
  logic [31:0] init_cnt_r;
  logic [31:0] cnt_slow_r;
  logic [31:0] cnt_mid_r;
  logic [31:0] cnt_fast_r;
  logic ph_slow_r;
  logic ph_mid_r;
  logic ph_fast_r;
  logic safety_run_r;
  logic ident_r;
  logic maint_en_r;
  logic client_en_r;
  logic pw_default_r;
  logic cfg_default_r;
  logic pw_reject_r;
  logic interlock_r;
  logic ap_valid_r;
  logic ap_write_r;
  logic [7:0] ap_addr_r;
  logic out_on_r;
  sisc_color_e out_lamp_r;
  sisc_color_e stat_lamp_r;

  // Address phase capture
  wire ap_take = hsel_i && hready_i && htrans_i[1];
  wire wr_en = ap_valid_r && ap_write_r;
  wire wr_cmd = wr_en && (ap_addr_r == ADDR_CMD);
  wire wr_ctrl = wr_en && (ap_addr_r == ADDR_CTRL);
  wire wr_code = wr_en && (ap_addr_r == ADDR_PWCODE);
  wire code_ok = wr_code && (hwdata_i == PW_KEY);
  wire code_bad = wr_code && (hwdata_i != PW_KEY);
  wire cmd_restart = wr_cmd && hwdata_i[CMD_RESTART];
  wire cmd_factory = wr_cmd && hwdata_i[CMD_FACTORY];
  wire cmd_start = wr_cmd && hwdata_i[CMD_START];
  wire cmd_stop = wr_cmd && hwdata_i[CMD_STOP];
  wire cmd_id_on = wr_cmd && hwdata_i[CMD_IDENT_ON];
  wire cmd_id_off = wr_cmd && hwdata_i[CMD_IDENT_OFF];
  wire running = (phase_r == SISC_PH_RUN);
  wire init_done = (init_cnt_r == 32'h0000_0001);

  wire [7:0] stat_word = {pw_reject_r, ident_r, cfg_default_r, pw_default_r, client_en_r,
                          maint_en_r, safety_run_r, !running};
  wire [7:0] lamp_word = {4'h0, 2'(out_lamp_r), 2'(stat_lamp_r)};
  wire [31:0] rd_word =
      (ap_addr_r == ADDR_STAT) ? {24'h00_0000, stat_word} :
      (ap_addr_r == ADDR_CTRL) ? {29'h0, !pw_default_r, client_en_r, maint_en_r} :
      (ap_addr_r == ADDR_LAMP) ? {24'h00_0000, lamp_word} : 32'h0000_0000;

  // Restart phase rewinds to initialization like a power cycle
  wire [31:0] init_cnt_nxt = (phase_r == SISC_PH_RESTART) ? INIT_CYCLES :
                             (phase_r == SISC_PH_INIT && init_cnt_r > 32'h1) ?
                             init_cnt_r - 32'h1 : init_cnt_r;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_r <= SISC_PH_RESTART;
      init_cnt_r <= 32'h0000_0000;
    end else begin
      init_cnt_r <= init_cnt_nxt;
      case (phase_r)
        SISC_PH_RESTART: phase_r <= SISC_PH_INIT;
        SISC_PH_INIT: if (init_done) phase_r <= SISC_PH_RUN;
        SISC_PH_RUN: if (cmd_restart) phase_r <= SISC_PH_RESTART;
        default: phase_r <= SISC_PH_RESTART;
      endcase
    end
  end

  // Blink dividers, all 50 percent duty
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_slow_r <= 32'h0;
      cnt_mid_r <= 32'h0;
      cnt_fast_r <= 32'h0;
      ph_slow_r <= 1'b0;
      ph_mid_r <= 1'b0;
      ph_fast_r <= 1'b0;
    end else begin
      cnt_slow_r <= (cnt_slow_r >= HALF_SLOW - 1) ? 32'h0 : cnt_slow_r + 32'h1;
      cnt_mid_r <= (cnt_mid_r >= HALF_MID - 1) ? 32'h0 : cnt_mid_r + 32'h1;
      cnt_fast_r <= (cnt_fast_r >= HALF_FAST - 1) ? 32'h0 : cnt_fast_r + 32'h1;
      if (cnt_slow_r >= HALF_SLOW - 1) ph_slow_r <= !ph_slow_r;
      if (cnt_mid_r >= HALF_MID - 1) ph_mid_r <= !ph_mid_r;
      if (cnt_fast_r >= HALF_FAST - 1) ph_fast_r <= !ph_fast_r;
    end
  end

  // Service state; restart clears volatile state but keeps stored settings
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      safety_run_r <= 1'b1;
      ident_r <= 1'b0;
      maint_en_r <= CTRL_RESET[CT_MAINT_EN];
      client_en_r <= CTRL_RESET[CT_CLIENT_EN];
      pw_default_r <= 1'b1;
      cfg_default_r <= 1'b0;
      pw_reject_r <= 1'b0;
      interlock_r <= 1'b0;
    end else if (phase_r == SISC_PH_RESTART) begin
      safety_run_r <= 1'b1;
      ident_r <= 1'b0;
      pw_reject_r <= 1'b0;
      interlock_r <= device_error_i && !fault_cleared_i;
    end else begin
      if (cmd_stop) safety_run_r <= 1'b0;
      else if (cmd_start) safety_run_r <= 1'b1;
      if (cmd_id_on) ident_r <= 1'b1;
      else if (cmd_id_off) ident_r <= 1'b0;
      if (device_error_i) interlock_r <= 1'b1;
      if (cmd_factory || code_ok) begin
        maint_en_r <= 1'b0;
        client_en_r <= 1'b0;
        pw_default_r <= 1'b1;
      end else if (wr_ctrl) begin
        maint_en_r <= hwdata_i[CT_MAINT_EN];
        client_en_r <= hwdata_i[CT_CLIENT_EN];
        if (hwdata_i[CT_PW_CHANGED]) pw_default_r <= 1'b0;
      end
      if (cmd_factory) cfg_default_r <= 1'b1;
      else if (cfg_verified_i) cfg_default_r <= 1'b0;
      if (code_bad) pw_reject_r <= 1'b1;
      else if (code_ok) pw_reject_r <= 1'b0;
    end
  end

  // Output switching; errors and interlock force OFF
  wire out_on_nxt = running && safety_run_r && safety_request_i && !interlock_r &&
                    !device_error_i && !recoverable_error_i && !contam_error_i &&
                    cfg_present_i && !cfg_faulty_i && (cfg_verified_i || test_mode_i);
  wire recov = recoverable_error_i || contam_error_i;
  wire unverif = cfg_present_i && !cfg_verified_i && !test_mode_i;

  // Priority chain for the status lamp
  sisc_color_e stat_nxt;
  always_comb begin
    if (!running) stat_nxt = SISC_LAMP_YELLOW;
    else if (ident_r) stat_nxt = ph_mid_r ? SISC_LAMP_RED : SISC_LAMP_GREEN;
    else if (sleep_i || !safety_run_r) stat_nxt = SISC_LAMP_OFF;
    else if (device_error_i || interlock_r) stat_nxt = ph_mid_r ? SISC_LAMP_RED : SISC_LAMP_OFF;
    else if (!cfg_present_i || cfg_faulty_i)
      stat_nxt = ph_mid_r ? SISC_LAMP_RED : SISC_LAMP_YELLOW;
    else if (unverif) stat_nxt = ph_mid_r ? SISC_LAMP_YELLOW : SISC_LAMP_GREEN;
    else if (recov) stat_nxt = ph_fast_r ? SISC_LAMP_YELLOW : SISC_LAMP_OFF;
    else if (test_mode_i) stat_nxt = ph_slow_r ? SISC_LAMP_GREEN : SISC_LAMP_OFF;
    else if (restart_delay_i) stat_nxt = ph_fast_r ? SISC_LAMP_GREEN : SISC_LAMP_OFF;
    else if (contam_warning_i) stat_nxt = ph_slow_r ? SISC_LAMP_YELLOW : SISC_LAMP_OFF;
    else if (warn_field_i) stat_nxt = SISC_LAMP_YELLOW;
    else stat_nxt = SISC_LAMP_GREEN;
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_on_r <= 1'b0;
      out_lamp_r <= SISC_LAMP_OFF;
      stat_lamp_r <= SISC_LAMP_OFF;
    end else begin
      out_on_r <= out_on_nxt;
      if (!running) out_lamp_r <= SISC_LAMP_RED;
      else out_lamp_r <= out_on_nxt ? SISC_LAMP_GREEN : SISC_LAMP_RED;
      stat_lamp_r <= stat_nxt;
    end
  end

  // AHB-Lite slave, zero wait states
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r <= 8'h00;
    end else begin
      if (hready_i) begin
        ap_valid_r <= ap_take;
        ap_write_r <= hwrite_i;
        ap_addr_r <= haddr_i[7:0];
      end
    end
  end

  assign hrdata_o = rd_word;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign safety_switching_output_o = out_on_r;
  assign output_lamp_o = out_lamp_r;
  assign status_lamp_o = stat_lamp_r;
  assign comm_drop_o = !running;
  assign core_reinit_o = (phase_r == SISC_PH_RESTART);
  assign cfg_restore_o = cmd_factory;
endmodule : sisc_top

// ---- test/sisc_chk.sv ----
// Port checker for the status lamp and service controller
`timescale 1ns/100ps
module sisc_chk
  import sisc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic device_error_i,
  input wire logic recoverable_error_i,
  input wire logic safety_switching_output_o,
  input wire sisc_pkg::sisc_color_e output_lamp_o,
  input wire sisc_pkg::sisc_color_e status_lamp_o,
  input wire logic comm_drop_o,
  input wire logic core_reinit_o,
  input wire logic cfg_restore_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_cmd_wr;
    hsel_i && htrans_i[1] && hwrite_i && haddr_i[7:0] == ADDR_CMD;
  endsequence
  // Three cycles give the registered lamps time to leave their reset value
  sequence s_init;
    (comm_drop_o && !core_reinit_o) [*3];
  endsequence
  property p_out_lamp;
    !comm_drop_o && $stable(safety_switching_output_o) |->
      output_lamp_o == (safety_switching_output_o ? SISC_LAMP_GREEN : SISC_LAMP_RED);
  endproperty
  a_out_lamp: assert property (p_out_lamp) else $error("output lamp wrong");
  property p_recov;
    recoverable_error_i |=> !safety_switching_output_o;
  endproperty
  a_recov: assert property (p_recov) else $error("outputs on in error");
  property p_init;
    s_init |-> status_lamp_o == SISC_LAMP_YELLOW && output_lamp_o == SISC_LAMP_RED;
  endproperty
  a_init: assert property (p_init) else $error("lamps dark in init");
  property p_reinit;
    core_reinit_o |-> comm_drop_o ##1 !core_reinit_o;
  endproperty
  a_reinit: assert property (p_reinit) else $error("bad reinit pulse");
  property p_drop;
    comm_drop_o && $past(comm_drop_o) |-> !safety_switching_output_o;
  endproperty
  a_drop: assert property (p_drop) else $error("outputs on in restart");
  property p_factory;
    cfg_restore_o |-> $past(hsel_i && htrans_i[1] && hwrite_i && haddr_i[7:0] == ADDR_CMD)
      && hwdata_i[CMD_FACTORY];
  endproperty
  a_factory: assert property (p_factory) else $error("stray restore");
  property p_stop;
    s_cmd_wr ##1 hwdata_i[CMD_STOP] |-> ##[1:2] !safety_switching_output_o;
  endproperty
  a_stop: assert property (p_stop) else $error("stop ignored");
  property p_err;
    device_error_i && $past(device_error_i) && !comm_drop_o && !$past(comm_drop_o) |->
      status_lamp_o != SISC_LAMP_YELLOW;
  endproperty
  a_err: assert property (p_err) else $error("error shown yellow");
endmodule : sisc_chk

bind sisc_top sisc_chk chk_u (.*);

// ---- test/sisc_tool.sv ----
// Configuration tool model: single word transfers as AHB-Lite master
`timescale 1ns/100ps
module sisc_tool (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic done_o = 1'b0,
  output logic [31:0] rdata_o = 32'h0,
  output logic hsel_o = 1'b0,
  output logic [31:0] haddr_o = 32'h0,
  output logic [1:0] htrans_o = 2'h0,
  output logic hwrite_o = 1'b0,
  output logic [2:0] hsize_o = 3'h2,
  output logic [31:0] hwdata_o = 32'h0
);
  logic [1:0] st_r = 2'h0;
  always @(posedge clk_i) begin
    case (st_r)
      2'h0: begin
        if (req_i) begin
          hsel_o <= 1'b1;
          haddr_o <= {24'h0, addr_i};
          htrans_o <= 2'h2;
          hwrite_o <= wr_i;
          done_o <= 1'b0;
          st_r <= 2'h1;
        end else begin
          // Released data lines invert every idle cycle, so they hold the old word again every second cycle
          hwdata_o <= ~hwdata_o;
        end
      end
      2'h1: begin
        if (hready_i) begin
          htrans_o <= 2'h0;
          hwdata_o <= wdata_i;
          st_r <= 2'h2;
        end
      end
      default: begin
        if (hready_i) begin
          rdata_o <= hrdata_i;
          done_o <= 1'b1;
          st_r <= 2'h0;
        end
      end
    endcase
  end
endmodule : sisc_tool

// ---- test/status_indicator_service_ctrl_bench.sv ----
// Self-checking bench for the status lamp and service controller
`timescale 1ns/100ps
module status_indicator_service_ctrl_bench;
  import sisc_pkg::*;
  localparam int HI = 20, HS = 10, HM = 6, HF = 4;
  localparam sisc_color_e R = SISC_LAMP_RED, Y = SISC_LAMP_YELLOW;
  localparam sisc_color_e G = SISC_LAMP_GREEN, K = SISC_LAMP_OFF;
  logic clk = 1'b0, rst = 1'b1, req = 1'b0, wr = 1'b0;
  logic [12:0] cd = 13'h0;
  logic [7:0] ad = 8'h0;
  logic [31:0] wd = 32'h0;
  logic c5;
  int num_errors = 0, checks = 0;
  wire logic done, hsel, hwrite, hready, hresp, sso, cdrop, rein, crst;
  wire logic [1:0] htrans;
  wire logic [2:0] hsize;
  wire logic [31:0] rdata, haddr, hwdata, hrdata;
  wire sisc_color_e ol, sl;
  always #4 clk = ~clk;
  sisc_tool tool_u (.clk_i(clk), .req_i(req), .wr_i(wr), .addr_i(ad), .wdata_i(wd),
    .hready_i(hready), .hrdata_i(hrdata), .done_o(done), .rdata_o(rdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));
  sisc_top #(.INIT_CYCLES(HI), .HALF_SLOW(HS), .HALF_MID(HM), .HALF_FAST(HF)) dut_u (
    .core_clk_i(clk), .reset_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .safety_request_i(cd[0]),
    .cfg_present_i(cd[1]), .cfg_faulty_i(cd[2]), .cfg_verified_i(cd[3]),
    .device_error_i(cd[4]), .recoverable_error_i(cd[5]), .contam_error_i(cd[6]),
    .contam_warning_i(cd[7]), .warn_field_i(cd[8]), .restart_delay_i(cd[9]),
    .test_mode_i(cd[10]), .sleep_i(cd[11]), .fault_cleared_i(cd[12]),
    .safety_switching_output_o(sso), .output_lamp_o(ol), .status_lamp_o(sl),
    .comm_drop_o(cdrop), .core_reinit_o(rein), .cfg_restore_o(crst));
  task chk(input logic [31:0] s, input logic [31:0] e, input string n);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    ad <= a;
    wd <= d;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    while (done !== 1'b1) @(negedge clk);
  endtask : bus
  task steady(input logic [12:0] c, input sisc_color_e x, input sisc_color_e o);
    @(posedge clk);
    cd <= c;
    repeat (8) @(negedge clk);
    chk(sl, x, "status lamp");
    if (o !== K) chk(ol, o, "output lamp");
    repeat (7) @(negedge clk);
    chk(sl, x, "status lamp held");
  endtask : steady
  // Measures one half period between two colour changes
  task blink(input logic [12:0] c, input sisc_color_e x, input sisc_color_e y, input int h);
    sisc_color_e a;
    int n;
    @(posedge clk);
    cd <= c;
    repeat (30) @(negedge clk);
    for (int i = 0; i < 2; i++) begin
      a = sl;
      n = 0;
      while (sl === a && n < 40) begin
        @(negedge clk);
        n++;
      end
    end
    chk(n, h, "half period");
    chk({a, sl} === {x, y} || {a, sl} === {y, x}, 1, "blink colours");
  endtask : blink
  task complete_run;
    $display("mismatches %0d comparisons %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(negedge clk);
    chk(sl, Y, "init status");
    chk(ol, R, "init output");
    repeat (HI) @(posedge clk);
    steady(13'h00B, G, G);
    steady(13'h00A, G, R);
    steady(13'h10B, Y, G);
    steady(13'h80B, K, K);
    blink(13'h02B, Y, K, HF);
    chk(sso, 0, "outputs in error");
    blink(13'h0AB, Y, K, HF);
    blink(13'h04B, Y, K, HF);
    blink(13'h20B, G, K, HF);
    blink(13'h08B, Y, K, HS);
    blink(13'h40B, G, K, HS);
    blink(13'h003, Y, G, HM);
    blink(13'h007, R, Y, HM);
    blink(13'h001, R, Y, HM);
    bus(1, ADDR_CMD, 32'h1 << CMD_IDENT_ON);
    blink(13'h00B, R, G, HM);
    bus(1, ADDR_CMD, 32'h1 << CMD_IDENT_OFF);
    bus(1, ADDR_CMD, 32'h1 << CMD_STOP);
    steady(13'h00B, K, R);
    bus(1, ADDR_CMD, 32'h1 << CMD_START);
    steady(13'h00B, G, G);
    bus(1, ADDR_CTRL, 32'h7);
    bus(0, ADDR_STAT, 32'h0);
    chk(rdata[4:2], 3'h3, "groups on");
    c5 = rdata[5];
    bus(1, ADDR_PWCODE, ~PW_KEY_DEFAULT);
    bus(0, ADDR_STAT, 32'h0);
    chk({rdata[7], rdata[4:2]}, 4'hB, "code refused");
    bus(1, ADDR_PWCODE, PW_KEY_DEFAULT);
    bus(0, ADDR_STAT, 32'h0);
    chk(rdata[5:2], {c5, 3'h4}, "code reset");
    bus(1, ADDR_CTRL, 32'h3);
    // A verified configuration would clear the default marker at once
    @(posedge clk);
    cd <= 13'h003;
    bus(1, ADDR_CMD, 32'h1 << CMD_FACTORY);
    bus(0, ADDR_STAT, 32'h0);
    chk(rdata[5:2], 4'hC, "factory reset");
    chk(hresp, 0, "bus response");
    @(posedge clk);
    cd <= 13'h00B;
    bus(0, ADDR_LAMP, 32'h0);
    chk(rdata[3:0], 4'hF, "lamp register");
    bus(0, 8'h20, 32'h0);
    chk(rdata, 32'h0, "unmapped read");
    blink(13'h01B, R, K, HM);
    // The fault cause is removed before the restart clears the interlock
    @(posedge clk);
    cd <= 13'h00B;
    bus(1, ADDR_CMD, 32'h1 << CMD_RESTART);
    chk(rein, 1, "reinit pulse");
    @(negedge clk);
    chk(cdrop, 1, "links dropped");
    chk(rein, 0, "reinit pulse end");
    repeat (HI + 10) @(posedge clk);
    steady(13'h00B, G, G);
    complete_run;
  end
endmodule : status_indicator_service_ctrl_bench
